// *** dv/input_cond_monitor.sv ***
// Purpose: Bus and filter checks for the input conditioning block
// Assumes: Zero wait states; a shadow of both registers follows writes
// Notes:   Filter checks hold only while filter codes stay put
`timescale 1ns/1ps
`include "input_cond_consts.vh"
module input_cond_monitor (
    input logic        clk,
    input logic        reset,
    input logic        hsel,
    input logic [31:0] haddr,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic [31:0] hwdata,
    input logic        hready,
    input logic [31:0] hrdata,
    input logic        hreadyout,
    input logic [3:0]  chan_pin,
    input logic        external_trigger_input,
    input logic [3:0]  chan_cond,
    input logic        trigger_cond
);
    logic        wr_ph;    // Write data phase pending
    logic [11:0] wr_a;     // Address of that write
    logic [15:0] chan_reg; // Shadow of channel register
    logic [2:0]  tcode;    // Shadow of trigger code
    logic [1:0]  up;       // Edges since reset, saturating
    wire  [3:0]  inv = {chan_reg[15], chan_reg[11], chan_reg[7], chan_reg[3]};
    wire  [3:0]  raw = chan_pin ^ inv;
    wire         take = hsel && hready && htrans[1];
    wire         rd_c = take && !hwrite && haddr[11:0] == `CHAN_IN_CTRL_OFF;
    wire         rd_t = take && !hwrite && haddr[11:0] == `TRIG_FILT_CTRL_OFF;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Shadow lets the checks know codes and inversion
    always @(posedge clk) begin
        if (reset) begin
            wr_ph <= 1'b0;
            chan_reg <= 16'h0;
            tcode <= 3'h0;
            up <= 2'h0;
        end else begin
            wr_ph <= take && hwrite;
            wr_a <= haddr[11:0];
            if (up != 2'h3)
                up <= up + 2'h1;
            if (wr_ph && wr_a == `CHAN_IN_CTRL_OFF)
                chan_reg <= hwdata[15:0];
            if (wr_ph && wr_a == `TRIG_FILT_CTRL_OFF)
                tcode <= hwdata[6:4];
        end
    end
    a_reset_clear: assert property (disable iff (1'b0) reset |=>
        chan_cond == 4'h0 && !trigger_cond && hrdata == 32'h0 && hreadyout)
        else $error("outputs not cleared by reset");
    a_read_chan: assert property (rd_c |=>
        hrdata == {16'h0, $past(chan_reg)}) else $error("channel read");
    a_read_trig: assert property (rd_t |=>
        hrdata == {25'h0, $past(tcode), 4'h0}) else $error("trigger read");
    a_chan_polarity: assert property (up == 2'h3 && $changed(chan_cond) |->
        ((chan_cond ^ $past(raw, 2)) & (chan_cond ^ $past(chan_cond))) == 4'h0)
        else $error("channel change against its pin");
    a_trig_bypass: assert property (up == 2'h3 && tcode == 3'h0 &&
        $past(tcode, 3) == 3'h0 |-> trigger_cond == $past(external_trigger_input, 2))
        else $error("unfiltered trigger delay");
    a_trig_six: assert property ($changed(trigger_cond) && tcode == 3'h3 |->
        $past(external_trigger_input, 2) == trigger_cond &&
        $past(external_trigger_input, 7) == trigger_cond)
        else $error("trigger accepted short run");
    a_chan_four: assert property ($changed(chan_cond[0]) &&
        chan_reg[2:0] == 3'h2 |-> $past(raw[0], 5) == chan_cond[0])
        else $error("channel accepted short run");
    a_trig_divided: assert property ($changed(trigger_cond) && tcode[2] |->
        (tcode[1] ? $past(external_trigger_input, 10) :
        $past(external_trigger_input, 6)) == trigger_cond)
        else $error("divided trigger sample spacing");
endmodule

// *** dv/input_conditioning_bench.sv ***
// Purpose: Register and filter tests for the input conditioning block
// Assumes: Zero wait state AHB-Lite slave, hready tied to hreadyout
// Notes:   Glitches span whole sample periods so counts are exact
`timescale 1ns/1ps
`include "input_cond_consts.vh"
module input_conditioning_bench;
    logic        clk = 1'b0;    // 25 MHz bus clock
    logic        reset = 1'b1;  // Held at start
    logic        hsel = 1'b0;   // Bus select
    logic        hwrite = 1'b0; // Write flag
    logic [1:0]  htrans = 2'h0; // Transfer type
    logic [31:0] haddr = 32'h0; // Byte address
    logic [31:0] hwdata = 32'h0;
    logic [31:0] q;             // Last read data
    logic [2:0]  kc;            // Filter code under test
    wire  [31:0] hrdata;
    wire         hready, hreadyout, hresp, trig_pin, trigger_cond;
    wire  [3:0]  chan_pin, chan_cond;
    int          n_fail = 0;
    int          checked = 0;
    int          nn [8] = '{0, 2, 4, 6, 4, 6, 4, 6}; // Samples per code
    int          dd [8] = '{1, 1, 1, 1, 4, 4, 8, 8}; // Divide per code
    int          lo, hi;
    always #20 clk = ~clk;
    assign hready = hreadyout;
    pin_source pin_source_i (.chan_pin(chan_pin), .trig_pin(trig_pin));
    input_conditioning input_conditioning_i (.clk(clk), .reset(reset),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .chan_pin(chan_pin),
        .external_trigger_input(trig_pin), .chan_cond(chan_cond),
        .trigger_cond(trigger_cond));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Bounded wait for hready at a rising edge
    task wait_ready;
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (hready === 1'b1)
                return;
        end
        n_fail++;
        stop_test;
    endtask
    // One single word transfer; response must be OKAY
    task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready;
        q = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask
    // New pin level; output must follow within lo+1 to hi edges
    task settle(input logic [4:0] p, input logic [4:0] e, input int l, h);
        int c;
        pin_source_i.drive(p);
        for (c = 1; c < h + 8; c++) begin
            @(posedge clk);
            if ({trigger_cond, chan_cond} === e)
                break;
        end
        check({31'h0, c > l && c <= h}, 32'h1);
    endtask
    // High pulse one sample short; outputs must stay low
    task glitch(input int len, input int hold);
        int i;
        logic bad;
        bad = 1'b0;
        pin_source_i.drive(5'h1f);
        for (i = 0; i < len + hold; i++) begin
            if (i == len)
                pin_source_i.drive(5'h00);
            @(posedge clk);
            if ({trigger_cond, chan_cond} !== 5'h00)
                bad = 1'b1;
        end
        check({31'h0, bad}, 32'h0);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        bus(1'b0, `CHAN_IN_CTRL_OFF, 32'h0);
        check(q, `CHAN_IN_CTRL_RST);
        bus(1'b0, `TRIG_FILT_CTRL_OFF, 32'h0);
        check(q, `TRIG_FILT_CTRL_RST);
        bus(1'b0, 12'h310, 32'h0);
        check(q, 32'h0);
        check({27'h0, trigger_cond, chan_cond}, 32'h0);
        $display("test reset done");
        // Channels two and four inverted; reserved bits kept zero
        bus(1'b1, `CHAN_IN_CTRL_OFF, 32'h8080);
        bus(1'b0, `CHAN_IN_CTRL_OFF, 32'h0);
        check(q, 32'h8080);
        settle(5'h00, 5'h0a, 0, 3);
        settle(5'h1f, 5'h15, 2, 3);
        bus(1'b1, `CHAN_IN_CTRL_OFF, 32'h0);
        settle(5'h00, 5'h00, 0, 6);
        $display("test polarity done");
        for (int k = 0; k < 8; k++) begin
            kc = k[2:0];
            bus(1'b1, `CHAN_IN_CTRL_OFF, {16'h0, {4{1'b0, kc}}});
            bus(1'b1, `TRIG_FILT_CTRL_OFF, {25'h0, kc, 4'h0});
            bus(1'b0, `CHAN_IN_CTRL_OFF, 32'h0);
            check(q, {16'h0, {4{1'b0, kc}}});
            bus(1'b0, `TRIG_FILT_CTRL_OFF, 32'h0);
            check(q, {25'h0, kc, 4'h0});
            lo = (k == 0) ? 2 : (nn[k] - 1) * dd[k] + 2;
            hi = (k == 0) ? 3 : (nn[k] + 1) * dd[k] + 3;
            if (k > 0)
                glitch((nn[k] - 1) * dd[k], hi);
            settle(5'h1f, 5'h1f, lo, hi);
            settle(5'h00, 5'h00, lo, hi);
            $display("test filter code %0d done", k);
        end
        stop_test;
    end
endmodule
bind input_conditioning input_cond_monitor input_cond_monitor_i (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .chan_pin(chan_pin),
    .external_trigger_input(external_trigger_input),
    .chan_cond(chan_cond), .trigger_cond(trigger_cond));

// *** dv/pin_source.sv ***
// Purpose: Pin source standing in for sensors and trigger sources
// Assumes: The bench calls drive just after a rising clock edge
// Notes:   Levels hold until the next call, like a driven pin
`timescale 1ns/1ps
module pin_source (
    output logic [3:0] chan_pin,
    output logic       trig_pin
);
    // All pins start low
    initial begin
        chan_pin = 4'h0;
        trig_pin = 1'b0;
    end
    // Non-blocking so the sampling edge never races the change
    task drive(input logic [4:0] v);
        {trig_pin, chan_pin} <= v;
    endtask
endmodule

// *** hw/input_conditioning.v ***
// Purpose: Timer input conditioning: channel polarity and glitch filters
// Assumes: AHB-Lite slave, single word transfers, one 25 MHz clock
// Notes:   Conditioned outputs feed capture, encoder and trigger logic
`timescale 1ns/1ps
`include "input_cond_consts.vh"

module input_conditioning (
    input  wire        clk,
    input  wire        reset,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Pins
    input  wire [3:0]  chan_pin,               // Channel input pins
    input  wire        external_trigger_input, // Trigger pin
    // Conditioned signals to the timer
    output reg  [3:0]  chan_cond,
    output reg         trigger_cond
);

    // Control registers
    reg [15:0] channel_input_control;   // Used bits only; rest read 0
    reg [2:0]  trigger_filter_sel;      // Trigger filter field

    // Address phase capture
    reg        wr_pending;              // Write data phase follows
    reg [11:0] wr_offset;               // Offset latched for write

    // Sample rate divider
    reg [2:0]  div_count;               // Free-running divide counter
    reg        tick_div4;               // One-cycle pulse every 4
    reg        tick_div8;               // One-cycle pulse every 8

    // Filter outputs
    wire [3:0] chan_filt;
    wire       trig_filt;
    wire [3:0] chan_pol;                // Pins after polarity select

    wire [3:0] chan_invert;             // Invert bits gathered
    wire [2:0] chan_one_filter_sel;
    wire [2:0] chan_two_filter_sel;
    wire [2:0] chan_three_filter_sel;
    wire [2:0] chan_four_filter_sel;

    wire       addr_phase;              // Valid transfer this cycle
    wire [31:0] chan_rst_word;          // Reset word of channel register
    wire [31:0] trig_rst_word;          // Reset word of trigger register

    // Read-back of a register by offset; unmapped reads zero
    function [31:0] read_reg;
        input [11:0] off;
        input [15:0] chan_reg;
        input [2:0]  trig_sel;
        begin
            if (off == `CHAN_IN_CTRL_OFF)
                read_reg = {16'h0000, chan_reg};
            else if (off == `TRIG_FILT_CTRL_OFF)
                read_reg = {25'h0, trig_sel, 4'h0};
            else
                read_reg = 32'h0000_0000;
        end
    endfunction

    assign chan_one_filter_sel   =
        channel_input_control[`CH1_FLT_LSB+2:`CH1_FLT_LSB];
    assign chan_two_filter_sel   =
        channel_input_control[`CH2_FLT_LSB+2:`CH2_FLT_LSB];
    assign chan_three_filter_sel =
        channel_input_control[`CH3_FLT_LSB+2:`CH3_FLT_LSB];
    assign chan_four_filter_sel  =
        channel_input_control[`CH4_FLT_LSB+2:`CH4_FLT_LSB];
    assign chan_invert = {channel_input_control[`CH4_INV_BIT],
                          channel_input_control[`CH3_INV_BIT],
                          channel_input_control[`CH2_INV_BIT],
                          channel_input_control[`CH1_INV_BIT]};

    assign chan_pol = chan_pin ^ chan_invert;

    assign addr_phase = hsel & hready & htrans[`HTRANS_ACTIVE_BIT];

    // Reset words; only the stored bits are kept, so slice on purpose
    assign chan_rst_word = `CHAN_IN_CTRL_RST;
    assign trig_rst_word = `TRIG_FILT_CTRL_RST;

    // Bus slave: zero wait states, always OKAY
    always @(posedge clk) begin
        if (reset) begin
            wr_pending <= 1'b0;
            wr_offset  <= 12'h000;
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_phase) begin
                wr_pending <= hwrite;
                wr_offset  <= haddr[11:0];
                // Read data is registered so it stands in the data phase
                if (!hwrite)
                    hrdata <= read_reg(haddr[11:0], channel_input_control,
                                       trigger_filter_sel);
                else
                    hrdata <= 32'h0000_0000;
            end else if (hready) begin
                wr_pending <= 1'b0;
            end
        end
    end

    // Register writes land in the data phase
    always @(posedge clk) begin
        if (reset) begin
            // all zeros, no invert, no filter
            channel_input_control <= chan_rst_word[`CHAN_IN_USED_MSB:0];
            trigger_filter_sel    <=
                trig_rst_word[`TRIG_FLT_MSB:`TRIG_FLT_LSB];
        end else if (wr_pending) begin
            // reserved bits are dropped, so they always read 0
            if (wr_offset == `CHAN_IN_CTRL_OFF)
                channel_input_control <= hwdata[`CHAN_IN_USED_MSB:0];
            if (wr_offset == `TRIG_FILT_CTRL_OFF)
                trigger_filter_sel <= hwdata[`TRIG_FLT_MSB:`TRIG_FLT_LSB];
        end
    end

    // Shared divider; one counter serves all five filters
    always @(posedge clk) begin
        if (reset) begin
            div_count <= 3'h0;
            tick_div4 <= 1'b0;
            tick_div8 <= 1'b0;
        end else begin
            div_count <= div_count + 3'h1;
            tick_div4 <= ({1'b0, div_count[1:0]} == `DIV_4_LAST);
            tick_div8 <= (div_count == `DIV_8_LAST);
        end
    end

    // channel codes 100-111 use the divided rates
    sample_filter u_filt_ch1 (
        .clk         (clk),
        .reset       (reset),
        .filter_sel  (chan_one_filter_sel),
        .sample_div1 (1'b1),
        .sample_div4 (tick_div4),
        .sample_div8 (tick_div8),
        .raw_in      (chan_pol[0]),
        .filtered    (chan_filt[0])
    );
    sample_filter u_filt_ch2 (
        .clk         (clk),
        .reset       (reset),
        .filter_sel  (chan_two_filter_sel),
        .sample_div1 (1'b1),
        .sample_div4 (tick_div4),
        .sample_div8 (tick_div8),
        .raw_in      (chan_pol[1]),
        .filtered    (chan_filt[1])
    );
    sample_filter u_filt_ch3 (
        .clk         (clk),
        .reset       (reset),
        .filter_sel  (chan_three_filter_sel),
        .sample_div1 (1'b1),
        .sample_div4 (tick_div4),
        .sample_div8 (tick_div8),
        .raw_in      (chan_pol[2]),
        .filtered    (chan_filt[2])
    );
    sample_filter u_filt_ch4 (
        .clk         (clk),
        .reset       (reset),
        .filter_sel  (chan_four_filter_sel),
        .sample_div1 (1'b1),
        .sample_div4 (tick_div4),
        .sample_div8 (tick_div8),
        .raw_in      (chan_pol[3]),
        .filtered    (chan_filt[3])
    );

    sample_filter u_filt_trig (
        .clk         (clk),
        .reset       (reset),
        .filter_sel  (trigger_filter_sel),
        .sample_div1 (1'b1),
        .sample_div4 (tick_div4),
        .sample_div8 (tick_div8),
        .raw_in      (external_trigger_input),
        .filtered    (trig_filt)
    );

    // Outputs straight from flip-flops
    always @(posedge clk) begin
        if (reset) begin
            chan_cond    <= 4'h0;
            trigger_cond <= 1'b0;
        end else begin
            chan_cond    <= chan_filt;
            trigger_cond <= trig_filt;
        end
    end

endmodule

// *** hw/sample_filter.v ***
// Purpose: One digital glitch filter with selectable rate and count
// Assumes: Sample enables come from the shared divider in the top
// Notes:   Except in bypass (code 0), output changes only after N equal samples in a row
`timescale 1ns/1ps
`include "input_cond_consts.vh"

module sample_filter (
    input  wire       clk,
    input  wire       reset,
    input  wire [2:0] filter_sel,   // Filter code
    input  wire       sample_div1,  // Every cycle
    input  wire       sample_div4,  // One cycle in four
    input  wire       sample_div8,  // One cycle in eight
    input  wire       raw_in,       // Polarity-corrected input
    output reg        filtered      // Conditioned output
);

    reg [2:0] run_count;  // Equal samples seen that differ from output
    reg [2:0] need;       // Samples required for this code
    reg       take;       // Sample strobe for this code

    // Decode sample rate and count from the code
    always @* begin
        case (filter_sel)
            `FLT_D1_N2: begin
                need = `SAMPLES_2;
                take = sample_div1;
            end
            `FLT_D1_N4: begin
                need = `SAMPLES_4;
                take = sample_div1;
            end
            `FLT_D1_N6: begin
                need = `SAMPLES_6;
                take = sample_div1;
            end
            `FLT_D4_N4: begin
                need = `SAMPLES_4;
                take = sample_div4;
            end
            `FLT_D4_N6: begin
                need = `SAMPLES_6;
                take = sample_div4;
            end
            `FLT_D8_N4: begin
                need = `SAMPLES_4;
                take = sample_div8;
            end
            `FLT_D8_N6: begin
                need = `SAMPLES_6;
                take = sample_div8;
            end
            default: begin
                need = `SAMPLES_2;
                take = 1'b0;
            end
        endcase
    end

    // Count consecutive differing samples; any agreeing sample restarts
    always @(posedge clk) begin
        if (reset) begin
            run_count <= 3'h0;
            filtered  <= 1'b0;
        end else if (filter_sel == `FLT_OFF) begin
            // Bypass: input passes with one register of delay
            run_count <= 3'h0;
            filtered  <= raw_in;
        end else if (take) begin
            if (raw_in == filtered) begin
                run_count <= 3'h0;
            end else if (run_count + 3'h1 >= need) begin
                // Enough equal samples: accept the new level
                run_count <= 3'h0;
                filtered  <= raw_in;
            end else begin
                run_count <= run_count + 3'h1;
            end
        end
    end

endmodule

// *** shared/input_cond_consts.vh ***
// Purpose: Offsets, field positions, reset values and filter codes
// Assumes: 32-bit AHB-Lite register bus, byte addresses
// Notes:   Definitions only
`ifndef INPUT_COND_CONSTS_VH
`define INPUT_COND_CONSTS_VH

// Register byte offsets (low 12 bits of haddr)
`define TRIG_FILT_CTRL_OFF   12'h30c
`define CHAN_IN_CTRL_OFF     12'h330
// Reset values
`define TRIG_FILT_CTRL_RST   32'h0000_0000
`define CHAN_IN_CTRL_RST     32'h0000_0000
// Channel register fields: invert bit and low bit of filter field
`define CH1_FLT_LSB          0
`define CH1_INV_BIT          3
`define CH2_FLT_LSB          4
`define CH2_INV_BIT          7
`define CH3_FLT_LSB          8
`define CH3_INV_BIT          11
`define CH4_FLT_LSB          12
`define CH4_INV_BIT          15
`define CHAN_IN_USED_MSB     15
// Trigger register field
`define TRIG_FLT_LSB         4
`define TRIG_FLT_MSB         6
// Filter codes
`define FLT_OFF              3'h0
`define FLT_D1_N2            3'h1
`define FLT_D1_N4            3'h2
`define FLT_D1_N6            3'h3
`define FLT_D4_N4            3'h4
`define FLT_D4_N6            3'h5
`define FLT_D8_N4            3'h6
`define FLT_D8_N6            3'h7
// Sample counts and clock divide ratios
`define SAMPLES_2            3'h2
`define SAMPLES_4            3'h4
`define SAMPLES_6            3'h6
`define DIV_4_LAST           3'h3
`define DIV_8_LAST           3'h7
// AHB transfer type bit that marks an active transfer
`define HTRANS_ACTIVE_BIT    1

`endif
